//--- verilog/srmf_framer.sv
// Receive message framer with AXI4-Lite registers and buffer window
`timescale 1ns/10ps
module srmf_framer
	import srmf_pkg::*;
#(
	parameter bit SECOND_CH = 1'b0
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [16:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [16:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	output logic             rx_ready,
	output logic             rx_read_request_flag,
	output logic             rx_abnormal_detect_flag
);
	import srmf_pkg::*;

	typedef enum logic [1:0] {
		ST_RECV,
		ST_CR_WAIT,
		ST_COUNT,
		ST_PENDING
	} srmf_state_e;

	function automatic logic start_ok(input logic [13:0] v);
		start_ok = ((v >= USR_A_LO) && (v <= USR_A_HI)) ||
			((v >= USR_B_LO) && (v <= USR_B_HI));
	endfunction

	function automatic logic len_ok(input logic [13:0] v);
		len_ok = (v >= LEN_MIN) && (v <= LEN_MAX);
	endfunction

	// ==========================================
	// Configuration and status registers
	logic [15:0] term_reg;
	logic        fmt_reg;
	logic        word_reg;
	logic [15:0] rxcount_reg;
	logic [13:0] start_reg;
	logic [13:0] len_reg;
	logic [15:0] idle_reg;
	logic [15:0] msgcnt_reg;
	logic        abn_kind_reg;
	srmf_state_e state_reg;
	logic [15:0] bcnt_reg;
	logic [7:0]  low_reg;

	// ==========================================
	// AXI write channel holding
	logic        aw_full_reg;
	logic        w_full_reg;
	logic [16:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_go;
	logic        wr_hit;

	assign s_axi_awready = !aw_full_reg;
	assign s_axi_wready  = !w_full_reg;
	assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= 17'h0_0000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (wr_go) begin
			w_full_reg <= 1'b0;
		end
	end

	always_comb begin
		case (aw_addr_reg & 17'h1_FFFC)
			REG_CTRL, REG_RXCOUNT, REG_START, REG_LEN,
			REG_IDLE, REG_STATUS: wr_hit = 1'b1;
			default:              wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register writes: a value outside its legal range is dropped whole
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			term_reg    <= TERM_CRLF;
			fmt_reg     <= 1'b0;
			word_reg    <= 1'b1;
			rxcount_reg <= RXCOUNT_RST;
			start_reg   <= SECOND_CH ? START_SECOND : START_FIRST;
			len_reg     <= LEN_RST;
			idle_reg    <= IDLE_US_RST;
		end else if (wr_go && (&w_strb_reg[1:0])) begin
			case (aw_addr_reg & 17'h1_FFFC)
				REG_CTRL: begin
					term_reg <= w_data_reg[15:0];
					if (w_strb_reg[2]) begin
						fmt_reg  <= w_data_reg[CTRL_FMT_BIT];
						word_reg <= w_data_reg[CTRL_WORD_BIT];
					end
				end
				REG_RXCOUNT: rxcount_reg <= w_data_reg[15:0];
				REG_START: begin
					if (start_ok(w_data_reg[13:0]) && (w_data_reg[15:14] == 2'b00)) begin
						start_reg <= w_data_reg[13:0];
					end
				end
				REG_LEN: begin
					if (len_ok(w_data_reg[13:0]) && (w_data_reg[15:14] == 2'b00)) begin
						len_reg <= w_data_reg[13:0];
					end
				end
				REG_IDLE: idle_reg <= w_data_reg[15:0];
				default: begin
				end
			endcase
		end
	end

	// ==========================================
	// Receive path decoding
	logic        acc;
	logic        mode_crlf;
	logic        mode_byte;
	logic [15:0] bcnt_next;
	logic [13:0] eff_cnt;
	logic [15:0] lim_bytes;
	logic [15:0] full_bytes;
	logic        hit_term;
	logic        hit_lf;
	logic        hit_cnt;
	logic        hit_full;
	logic        done;
	logic        cr_seen;
	logic        tmo;
	logic        host_clear;
	logic        buf_we;
	logic [13:0] buf_waddr;
	logic [15:0] buf_wdata;
	logic [13:0] buf_raddr;
	logic [15:0] buf_rdata;

	assign rx_ready  = (state_reg == ST_RECV) || (state_reg == ST_CR_WAIT);
	assign acc       = rx_valid && rx_ready;
	assign mode_crlf = (term_reg == TERM_CRLF);
	assign mode_byte = !mode_crlf && (term_reg != TERM_NONE);
	assign bcnt_next = bcnt_reg + 16'h0001;

	// Count larger than the area falls back to area length minus one
	assign eff_cnt = ({2'b00, rxcount_reg[13:0]} > {2'b00, len_reg - 14'h0001}) ||
		(rxcount_reg[15:14] != 2'b00) ? len_reg - 14'h0001 : rxcount_reg[13:0];
	assign lim_bytes  = word_reg ? {1'b0, eff_cnt, 1'b0} : {2'b00, eff_cnt};
	assign full_bytes = {1'b0, len_reg - 14'h0001, 1'b0};

	assign hit_term = mode_byte && (rx_data == term_reg[7:0]);
	assign hit_lf   = mode_crlf && (state_reg == ST_CR_WAIT) && (rx_data == CHAR_LF);
	assign hit_cnt  = (eff_cnt != 14'h0000) && (bcnt_next == lim_bytes);
	assign hit_full = (bcnt_next == full_bytes);
	assign done     = hit_term || hit_lf || hit_cnt || hit_full;
	assign cr_seen  = acc && mode_crlf && (rx_data == CHAR_CR) && !done;

	assign host_clear = wr_go && ((aw_addr_reg & 17'h1_FFFC) == REG_STATUS) &&
		w_strb_reg[0] && (w_data_reg[1:0] != 2'b00) && (state_reg == ST_PENDING);

	// ==========================================
	// Framing state machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg    <= ST_RECV;
			bcnt_reg     <= 16'h0000;
			low_reg      <= 8'h00;
			abn_kind_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_RECV, ST_CR_WAIT: begin
					if (acc) begin
						bcnt_reg <= bcnt_next;
						low_reg  <= rx_data;
						if (done) begin
							abn_kind_reg <= 1'b0;
							state_reg    <= ST_COUNT;
						end else if (cr_seen) begin
							state_reg <= ST_CR_WAIT;
						end else begin
							state_reg <= ST_RECV;
						end
					end else if (tmo && (state_reg == ST_CR_WAIT)) begin
						abn_kind_reg <= !fmt_reg;
						state_reg    <= ST_COUNT;
					end
				end
				ST_COUNT: begin
					state_reg <= ST_PENDING;
				end
				ST_PENDING: begin
					if (host_clear) begin
						bcnt_reg  <= 16'h0000;
						state_reg <= ST_RECV;
					end
				end
				default: begin
					state_reg <= ST_RECV;
				end
			endcase
		end
	end

	// Length word is written last, so a reader never sees a stale count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_read_request_flag    <= 1'b0;
			rx_abnormal_detect_flag <= 1'b0;
			msgcnt_reg              <= 16'h0000;
		end else if (state_reg == ST_COUNT) begin
			rx_read_request_flag    <= !abn_kind_reg;
			rx_abnormal_detect_flag <= abn_kind_reg;
			msgcnt_reg              <= buf_wdata;
		end else if (host_clear) begin
			rx_read_request_flag    <= 1'b0;
			rx_abnormal_detect_flag <= 1'b0;
		end
	end

	// Every byte is written at once; an even-position byte goes in with a zero upper half
	always_comb begin
		buf_we    = 1'b0;
		buf_waddr = start_reg;
		buf_wdata = 16'h0000;
		if (state_reg == ST_COUNT) begin
			buf_we    = 1'b1;
			buf_waddr = start_reg;
			buf_wdata = word_reg ? (bcnt_reg + 16'h0001) >> 1 : bcnt_reg;
		end else if (acc) begin
			buf_we    = 1'b1;
			buf_waddr = start_reg + 14'h0001 + bcnt_reg[14:1];
			buf_wdata = bcnt_reg[0] ? {rx_data, low_reg} :
				{8'h00, rx_data};
		end
	end

	srmf_idle_timer u_timer (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.start    (cr_seen),
		.stop     (acc),
		.limit_us (idle_reg),
		.expired  (tmo)
	);

	srmf_buffer #(
		.AW (14)
	) u_buf (
		.aclk  (aclk),
		.we    (buf_we),
		.waddr (buf_waddr),
		.wdata (buf_wdata),
		.raddr (buf_raddr),
		.rdata (buf_rdata)
	);

	// ==========================================
	// AXI read channel: three cycles, since the buffer read is registered
	logic        rd_busy_reg;
	logic        rd_stage_reg;
	logic        rd_wait_reg;
	logic [16:0] ar_addr_reg;
	logic [31:0] rd_word;
	logic        rd_err;

	assign s_axi_arready = !rd_busy_reg;
	assign buf_raddr = ar_addr_reg[15:2];

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_err  = 1'b0;
		if (ar_addr_reg[16]) begin
			rd_word = {16'h0000, buf_rdata};
		end else begin
			case (ar_addr_reg & 17'h1_FFFC)
				REG_CTRL:    rd_word = {14'h0000, word_reg, fmt_reg, term_reg};
				REG_RXCOUNT: rd_word = {16'h0000, rxcount_reg};
				REG_START:   rd_word = {18'h0_0000, start_reg};
				REG_LEN:     rd_word = {18'h0_0000, len_reg};
				REG_IDLE:    rd_word = {16'h0000, idle_reg};
				REG_STATUS:  rd_word = {30'h0000_0000, rx_abnormal_detect_flag,
					rx_read_request_flag};
				REG_MSGCNT:  rd_word = {16'h0000, msgcnt_reg};
				default:     rd_err  = 1'b1;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_busy_reg  <= 1'b0;
			rd_stage_reg <= 1'b0;
			rd_wait_reg  <= 1'b0;
			ar_addr_reg  <= 17'h0_0000;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else begin
			rd_stage_reg <= 1'b0;
			// Buffer word settles one edge after the address is held
			rd_wait_reg  <= rd_stage_reg;
			if (s_axi_arvalid && s_axi_arready) begin
				rd_busy_reg  <= 1'b1;
				rd_stage_reg <= 1'b1;
				ar_addr_reg  <= s_axi_araddr;
			end
			if (rd_wait_reg) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				rd_busy_reg  <= 1'b0;
			end
		end
	end
endmodule // srmf_framer

//--- verilog/srmf_pkg.sv
// Constants and register map of the serial receive message framer
package srmf_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [16:0] REG_CTRL     = 17'h0_0000;
	localparam logic [16:0] REG_RXCOUNT  = 17'h0_0004;
	localparam logic [16:0] REG_START    = 17'h0_0008;
	localparam logic [16:0] REG_LEN      = 17'h0_000C;
	localparam logic [16:0] REG_IDLE     = 17'h0_0010;
	localparam logic [16:0] REG_STATUS   = 17'h0_0014;
	localparam logic [16:0] REG_MSGCNT   = 17'h0_0018;
	localparam logic [16:0] BUF_WINDOW   = 17'h1_0000;
	// ==========================================
	// Control fields
	localparam int CTRL_FMT_BIT          = 16;
	localparam int CTRL_WORD_BIT         = 17;
	localparam logic [15:0] TERM_CRLF    = 16'h0D0A;
	localparam logic [15:0] TERM_NONE    = 16'hFFFF;
	localparam logic [7:0]  CHAR_CR      = 8'h0D;
	localparam logic [7:0]  CHAR_LF      = 8'h0A;
	// ==========================================
	// Reset values and legal ranges
	localparam logic [15:0] RXCOUNT_RST  = 16'h01FF;
	localparam logic [13:0] START_FIRST  = 14'h0600;
	localparam logic [13:0] START_SECOND = 14'h0A00;
	localparam logic [13:0] LEN_RST      = 14'h0200;
	localparam logic [13:0] USR_A_LO     = 14'h0400;
	localparam logic [13:0] USR_A_HI     = 14'h1AFF;
	localparam logic [13:0] USR_B_LO     = 14'h2600;
	localparam logic [13:0] USR_B_HI     = 14'h3FFF;
	localparam logic [13:0] LEN_MIN      = 14'h0001;
	localparam logic [13:0] LEN_MAX      = 14'h1A00;
	// ==========================================
	// Timing: idle gap counted in microsecond ticks
	localparam int CLK_NS                = 10;
	localparam int TICK_NS               = 1000;
	localparam int TICK_CYCLES           = TICK_NS / CLK_NS;
	localparam logic [15:0] IDLE_US_RST  = 16'h000A;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage

//--- verilog/srmf_buffer.sv
// Buffer memory words: one write port, one registered read port
`timescale 1ns/10ps
module srmf_buffer #(
	parameter int AW = 14
) (
	input  wire logic          aclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [15:0]   wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [15:0]   rdata
);
	logic [15:0] mem [0:(1<<AW)-1];

	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// No reset: contents are undefined until written
	always_ff @(posedge aclk) begin
		rdata <= mem[raddr];
	end
endmodule // srmf_buffer

//--- verilog/srmf_idle_timer.sv
// Idle-gap timer: microsecond divider and gap counter
`timescale 1ns/10ps
module srmf_idle_timer
	import srmf_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        start,
	input  wire logic        stop,
	input  wire logic [15:0] limit_us,
	output logic             expired
);
	localparam logic [7:0] DIV_TOP = 8'(TICK_CYCLES - 1);
	logic [7:0]  div_reg;
	logic [15:0] cnt_reg;
	logic        run_reg;
	logic        tick;

	assign tick = (div_reg == DIV_TOP);

	always_ff @(posedge aclk) begin
		if (!aresetn || start || tick) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_reg <= 1'b0;
			cnt_reg <= 16'h0000;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (start) begin
				run_reg <= 1'b1;
				cnt_reg <= 16'h0000;
			end else if (stop) begin
				run_reg <= 1'b0;
			end else if (run_reg && tick) begin
				cnt_reg <= cnt_reg + 16'h0001;
				if (cnt_reg + 16'h0001 >= limit_us) begin
					run_reg <= 1'b0;
					expired <= 1'b1;
				end
			end
		end
	end
endmodule // srmf_idle_timer

//--- sim/srmf_checker.sv
// Port assertions for the receive message framer
`timescale 1ns/10ps
module srmf_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        rx_valid,
	input wire logic        rx_ready,
	input wire logic        rx_read_request_flag,
	input wire logic        rx_abnormal_detect_flag
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========
	// Reception flags
	AST_PEND_NO_RX: assert property (rx_read_request_flag |-> !rx_ready)
		else $error("rx_ready high while a message waits");
	AST_ABN_NO_RX: assert property (rx_abnormal_detect_flag |-> !rx_ready)
		else $error("rx_ready high while abnormal flag is set");
	AST_ONE_FLAG: assert property (!(rx_read_request_flag && rx_abnormal_detect_flag))
		else $error("both completion flags high");
	AST_DONE_FLAG: assert property (rx_valid && rx_ready ##1 !rx_ready |=> rx_read_request_flag)
		else $error("no read request after final byte");
	AST_FLAG_CLEAR: assert property ($fell(rx_read_request_flag) |-> $rose(s_axi_bvalid))
		else $error("read request dropped without a host write");
	AST_ABN_HOLD: assert property (rx_abnormal_detect_flag && !$past(s_axi_wvalid) && !s_axi_wvalid
		|=> rx_abnormal_detect_flag)
		else $error("abnormal flag dropped on its own");
	// ==========
	// Register bus
	AST_B_AFTER_WR: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && !s_axi_bvalid |=> ##1 s_axi_bvalid)
		else $error("write response late");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid)
		else $error("read data late");
	AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	cover property ($rose(rx_read_request_flag));
	cover property ($rose(rx_abnormal_detect_flag));
	cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // srmf_checker

bind srmf_framer srmf_checker chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_read_request_flag(rx_read_request_flag),
	.rx_abnormal_detect_flag(rx_abnormal_detect_flag));

//--- sim/srmf_sender.sv
// External serial sender model feeding bytes to the framer
`timescale 1ns/10ps
module srmf_sender (
	input  wire logic       aclk,
	input  wire logic       rx_ready,
	output logic            rx_valid,
	output logic      [7:0] rx_data
);
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h5A;
	end
	// Caller ends q with the byte that closes the message, or with the CR that starts an idle gap, and keeps q within the area
	task automatic send(input logic [7:0] q[$], input bit slow);
		bit h;
		foreach (q[i]) begin
			rx_valid <= 1'b1;
			rx_data  <= q[i];
			do begin
				@(negedge aclk);
				h = rx_ready;
				@(posedge aclk);
			end while (!h);
			// Released line shows the inverse so no stale byte looks valid
			if (slow || i == q.size() - 1) begin
				rx_valid <= 1'b0;
				rx_data  <= ~q[i];
				@(posedge aclk);
			end
		end
	endtask
endmodule // srmf_sender

//--- sim/srmf_framer_bench.sv
// Self-checking bench for the receive message framer
`timescale 1ns/10ps
module srmf_framer_bench;
	import srmf_pkg::*;
	logic        aclk, aresetn, awv, wv, brdy, arv, rrdy, awr, wrd, bv, arr, rv;
	logic        rxv, rxr, rrq, rab;
	logic [7:0]  rxd;
	logic [16:0] awa, ara;
	logic [31:0] wd, rdat;
	logic [3:0]  wst;
	logic [1:0]  bresp, rresp, r;
	logic [13:0] start;
	logic [15:0] lf;
	logic [7:0]  q[$];
	int          failures, checks, cyc;
	logic [16:0] ta [7] = '{REG_START, REG_START, REG_START, REG_LEN, REG_LEN, REG_LEN, REG_IDLE};
	logic [31:0] tv [7] = '{32'h0000_0300, 32'h0000_1B00, 32'h0000_2600, 32'h0000_0000,
		32'h0000_1A01, 32'h0000_1A00, 32'h0000_0001};
	logic [31:0] te [7] = '{32'h0000_0600, 32'h0000_0600, 32'h0000_2600, 32'h0000_0200,
		32'h0000_0200, 32'h0000_1A00, 32'h0000_0001};
	logic [15:0] tc [2] = '{16'h0024, 16'h0000};
	srmf_framer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .rx_valid(rxv),
		.rx_data(rxd), .rx_ready(rxr), .rx_read_request_flag(rrq),
		.rx_abnormal_detect_flag(rab));
	srmf_sender snd_u (.aclk(aclk), .rx_ready(rxr), .rx_valid(rxv), .rx_data(rxd));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// ==========
	// Register bus master
	task automatic wr(input logic [16:0] a, input logic [31:0] d, output logic [1:0] p);
		logic ha, hw;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		do begin
			@(negedge aclk);
			ha = awv && awr;
			hw = wv && wrd;
			@(posedge aclk);
			if (ha)
				awv <= 1'b0;
			if (hw)
				wv <= 1'b0;
		end while (awv || wv);
		do begin
			@(negedge aclk);
			ha = bv;
			p = bresp;
			@(posedge aclk);
		end while (!ha);
	endtask
	task automatic rd(input logic [16:0] a, output logic [31:0] d, output logic [1:0] p);
		logic h;
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do begin
			@(negedge aclk);
			h = arr;
			@(posedge aclk);
		end while (!h);
		arv <= 1'b0;
		do begin
			@(negedge aclk);
			h = rv;
			d = rdat;
			p = rresp;
			@(posedge aclk);
		end while (!h);
	endtask
	task automatic rchk(input string n, input logic [16:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  p;
		rd(a, d, p);
		chk(n, e, d);
		chk({n, " resp"}, {30'h0, (a[16] || a < 17'h0_001C) ? RESP_OKAY : RESP_SLVERR},
			{30'h0, p});
	endtask
	// ==========
	// Message model: bytes paired low first, length word ahead of data
	function automatic logic [7:0] rb();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return {2'b01, lf[5:0]};
	endfunction
	task automatic fill(input int k);
		repeat (k) q.push_back(rb());
	endtask
	task automatic msg(input bit wm, input bit abn);
		int          n, lw, k;
		logic        a, b;
		logic [15:0] w;
		a = 1'b0;
		b = 1'b0;
		snd_u.send(q, q.size() % 2 == 1);
		n = q.size();
		lw = wm ? (n + 1) / 2 : n;
		for (k = 0; k < 3000 && !(a || b); k++) begin
			@(negedge aclk);
			a = rrq;
			b = rab;
		end
		@(posedge aclk);
		chk("read request", {31'h0, !abn}, {31'h0, a});
		chk("abnormal", {31'h0, abn}, {31'h0, b});
		rchk("msg count", REG_MSGCNT, lw);
		rchk("length word", 17'(BUF_WINDOW + 4 * start), lw);
		for (k = 0; k < n; k += 2) begin
			w = {(k + 1 < n) ? q[k + 1] : 8'h00, q[k]};
			rchk("data word", 17'(BUF_WINDOW + 4 * (start + 1 + k / 2)), {16'h0, w});
		end
		wr(REG_STATUS, 32'h0000_0003, r);
		rchk("status", REG_STATUS, 32'h0);
		q = {};
	endtask
	initial begin
		{aresetn, awv, wv, brdy, arv, rrdy, cyc, failures, checks} = '0;
		{awa, ara, wd} = '0;
		wst = 4'hF;
		lf = 16'd29965;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk("ctrl", REG_CTRL, 32'h0002_0D0A);
		rchk("rxcount", REG_RXCOUNT, 32'h0000_01FF);
		rchk("start", REG_START, 32'h0000_0600);
		wst <= 4'h3;
		wr(REG_CTRL, 32'h0001_0D0A, r);
		wst <= 4'hF;
		rchk("ctrl strobe", REG_CTRL, 32'h0002_0D0A);
		foreach (ta[i]) begin
			wr(ta[i], tv[i], r);
			rchk("range", ta[i], te[i]);
		end
		// Area at 2600h stays clear of any other buffer in this bench
		start = 14'h2600;
		wr(17'h0_0040, 32'h0000_0001, r);
		chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		rchk("unmapped read", 17'h0_0040, 32'h0);
		wr(REG_CTRL, 32'h0000_0D0A, r);
		fill(5);
		q.push_back(CHAR_CR);
		q.push_back(CHAR_LF);
		msg(0, 0);
		fill(4);
		q.push_back(CHAR_CR);
		msg(0, 1);
		wr(REG_CTRL, 32'h0001_0D0A, r);
		fill(3);
		q.push_back(CHAR_CR);
		msg(0, 0);
		foreach (tc[i]) begin
			wr(REG_CTRL, {16'h0002, tc[i]}, r);
			fill(4);
			q.push_back(tc[i][7:0]);
			msg(1, 0);
		end
		wr(REG_CTRL, 32'h0002_FFFF, r);
		wr(REG_RXCOUNT, 32'h0000_0004, r);
		fill(3);
		q.push_back(CHAR_CR);
		q.push_back(CHAR_LF);
		fill(3);
		msg(1, 0);
		wr(REG_CTRL, 32'h0002_0024, r);
		wr(REG_RXCOUNT, 32'h0000_000A, r);
		fill(3);
		q.push_back(8'h24);
		msg(1, 0);
		wr(REG_CTRL, 32'h0000_FFFF, r);
		wr(REG_RXCOUNT, 32'h0000_0100, r);
		wr(REG_LEN, 32'h0000_0004, r);
		fill(3);
		msg(0, 0);
		conclude();
	end
endmodule // srmf_framer_bench
